// ### verilog/sram_port_defines.vh
// Purpose: shared constants for the synchronous burst static RAM port
// Assumes: included by bare name from every design file
// Notes: timing counts are in clock cycles of SYS_CLK
`ifndef SRAM_PORT_DEFINES_VH
`define SRAM_PORT_DEFINES_VH
// geometry defaults
`define ADDR_W_DEF 8
`define LANES_DEF 4
`define LANE_W_DEF 9
`define FIFO_DEPTH_DEF 4
// burst counter
`define BURST_W 2
`define BURST_ZERO 2'h0
`define BURST_ONE 2'h1
// sleep entry delay in cycles
`define SLEEP_DELAY 2'h2
// write data follows command by this many edges
`define WR_LAT_FLOW 2'h1
`define WR_LAT_PIPE 2'h2
// command kinds of the control state
`define CMD_DESEL 2'h0
`define CMD_READ 2'h1
`define CMD_WRITE 2'h2
`define CMD_ABORT 2'h3
`endif

// ### verilog/burst_addr_gen.v
// Purpose: two-bit burst counter and low address bit former
// Assumes: same clock as the port, ce gates all state
// Notes: linear or interleaved order selected per access
`timescale 1ns/1ps
`include "sram_port_defines.vh"
module burst_addr_gen (
  // clock and control
  input wire clk,
  input wire srst,
  input wire ce,
  // load and advance
  input wire load,
  input wire advance,
  input wire interleave,
  input wire [1:0] start_low,
  // formed low bits for the current access
  output wire [1:0] low_bits
);
  // start low bits held for the whole burst
  reg [1:0] start_ff;
  // access count within the burst
  reg [1:0] count_ff;
  wire [1:0] nxt_count;
  // start bits that apply to this edge: the pins on a load, the held ones on a continue
  wire [1:0] use_start;
  // count wraps after four accesses, so the fifth repeats the start
  // wrap after four
  assign nxt_count = load ? `BURST_ZERO : (count_ff + `BURST_ONE);
  // counter and start register
  always @(posedge clk) begin
    if (srst) begin
      start_ff <= `BURST_ZERO;
      count_ff <= `BURST_ZERO;
    end else if (ce && (load || advance)) begin
      count_ff <= nxt_count;
      if (load) begin
        start_ff <= start_low;
      end
    end
  end
  // interleaved by xor
  // formed from the next count, so a continue edge already uses the advanced address;
  // adding one after the xor would break interleaved order for odd start values
  assign use_start = load ? start_low : start_ff;
  assign low_bits = interleave ? (use_start ^ nxt_count) : (use_start + nxt_count);
endmodule // burst_addr_gen

// ### verilog/word_fifo.v
// Purpose: small first-in first-out buffer on read data
// Assumes: single clock, ce freezes both pointers
// Notes: depth must be a power of two
`timescale 1ns/1ps
`include "sram_port_defines.vh"
module word_fifo #(
  parameter WIDTH = 36,
  parameter DEPTH = `FIFO_DEPTH_DEF,
  parameter PTR_W = 2
) (
  // clock and control
  input wire clk,
  input wire srst,
  input wire ce,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  // storage held in flip-flops
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [PTR_W:0] wr_ptr_ff;
  reg [PTR_W:0] rd_ptr_ff;
  wire full;
  wire empty;
  wire push;
  wire pop;
  // extra pointer bit tells full from empty
  assign empty = (wr_ptr_ff == rd_ptr_ff);
  assign full = (wr_ptr_ff[PTR_W] != rd_ptr_ff[PTR_W]) &&
                (wr_ptr_ff[PTR_W-1:0] == rd_ptr_ff[PTR_W-1:0]);
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign push = ce & in_valid & ~full;
  assign pop = ce & out_ready & ~empty;
  assign out_data = mem_ff[rd_ptr_ff[PTR_W-1:0]];
  // pointers and storage
  always @(posedge clk) begin
    if (srst) begin
      wr_ptr_ff <= {(PTR_W+1){1'b0}};
      rd_ptr_ff <= {(PTR_W+1){1'b0}};
    end else begin
      if (push) begin
        mem_ff[wr_ptr_ff[PTR_W-1:0]] <= in_data;
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end
endmodule // word_fifo

// ### verilog/sync_sram_burst_port.v
// Purpose: device side of a synchronous burst static RAM with late write
// Assumes: controller drives all pins on rising SYS_CLK; flow/pipe mode static
// Notes: core array in flip-flops; read data queued in a small buffer before pipelined drive
`timescale 1ns/1ps
`include "sram_port_defines.vh"
// Operation
// - flow-through reads drive one cycle earlier
// - read begins on full select, write high
// - output disable makes read a dummy
// - write begins with some byte strobe low
// - advance-load high continues burst, ignores selects
// - write with no strobes writes nothing
// - any inactive select deselects, floats bus
// - deselect continue only after a deselect
// - clock gate high holds all state except sync flops, sleep counter and the enable drop
// - stall keeps pipelined read driven, writes float
// - drivers off during write cycles
// - sleep request floats bus, ignores inputs
// - outputs float from power-up onward
// - two-bit counter replaces low address bits
// - load takes external address, advance counts
// - counter wraps after four accesses
// - linear order increments modulo four
// - flow-through select low, pipelined otherwise
// - pipelined write data two edges later
// - sleep entered two cycles after request
module sync_sram_burst_port #(
  parameter ADDR_W = `ADDR_W_DEF,
  parameter LANES = `LANES_DEF,
  parameter LANE_W = `LANE_W_DEF
) (
  // clock, reset, clock enable
  input wire SYS_CLK,
  input wire SRST,
  input wire CLK_EN,
  // address and command pins
  input wire [ADDR_W-1:0] ADDR,
  input wire CLK_GATE_N,
  input wire ADVANCE_LOAD,
  input wire WRITE_N,
  input wire [LANES-1:0] BYTE_WRITE_N,
  input wire CHIP_SEL_FIRST_N,
  input wire CHIP_SEL_SECOND,
  input wire CHIP_SEL_THIRD_N,
  input wire OUT_DRIVE_N,
  // mode pins
  input wire SLEEP_REQUEST,
  input wire LINEAR_ORDER_N,
  input wire FLOW_THROUGH_N,
  // data bus as three signals
  input wire [LANES*LANE_W-1:0] DQ_IN,
  output reg [LANES*LANE_W-1:0] DQ_OUT,
  output reg [LANES*LANE_W-1:0] DQ_OE,
  // status
  output reg ASLEEP
);
  localparam DATA_W = LANES * LANE_W;
  localparam DEPTH = 1 << ADDR_W;
  // data i/o states
  localparam ST_IDLE = 2'h0;
  localparam ST_DRIVE = 2'h1;
  localparam ST_WRITE = 2'h2;

  // two-flop synchronisers on the asynchronous pins
  reg sleep_s1_ff;
  reg sleep_s2_ff;
  reg oe_s1_ff;
  reg oe_s2_ff;
  // sleep entry counter
  reg [1:0] sleep_cnt_ff;
  reg [1:0] nxt_sleep_cnt;
  reg asleep_ff;
  // memory array
  reg [DATA_W-1:0] mem_ff [0:DEPTH-1];
  // registered address of the last loaded burst
  reg [ADDR_W-1:0] base_ff;
  // last control command, for continue and deselect-continue
  reg [1:0] last_cmd_ff;
  reg [1:0] nxt_cmd;
  // pending write pipeline: two stages for double late write
  reg wr1_vld_ff;
  reg [ADDR_W-1:0] wr1_addr_ff;
  reg [LANES-1:0] wr1_be_ff;
  reg wr2_vld_ff;
  reg [ADDR_W-1:0] wr2_addr_ff;
  reg [LANES-1:0] wr2_be_ff;
  // data i/o state
  reg [1:0] io_state_ff;
  reg [1:0] nxt_io_state;
  // decode terms
  wire active;
  wire selected;
  wire any_byte;
  wire is_load;
  wire [1:0] low_bits;
  wire [ADDR_W-1:0] cur_addr;
  wire [ADDR_W-1:0] access_addr;
  wire pipe_mode;
  wire wr_cycle;
  wire rd_cycle;
  // landing write (address, lanes) for this edge
  wire land_vld;
  wire [ADDR_W-1:0] land_addr;
  wire [LANES-1:0] land_be;
  // buffer signals
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [DATA_W-1:0] fifo_out_data;
  wire rd_push;
  wire drain;
  // byte-merged write word
  wire [DATA_W-1:0] merged;

  // synchronise sleep and output enable, second flop only is read
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      sleep_s1_ff <= 1'b0;
      sleep_s2_ff <= 1'b0;
      oe_s1_ff <= 1'b1;
      oe_s2_ff <= 1'b1;
    end else if (CLK_EN) begin
      sleep_s1_ff <= SLEEP_REQUEST;
      sleep_s2_ff <= sleep_s1_ff;
      oe_s1_ff <= OUT_DRIVE_N;
      oe_s2_ff <= oe_s1_ff;
    end
  end

  // sleep counter: asleep two cycles after request seen
  always @* begin
    nxt_sleep_cnt = sleep_cnt_ff;
    if (!sleep_s2_ff) begin
      nxt_sleep_cnt = 2'h0;
    end else if (sleep_cnt_ff != `SLEEP_DELAY) begin
      nxt_sleep_cnt = sleep_cnt_ff + 2'h1;
    end
  end
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      sleep_cnt_ff <= 2'h0;
      asleep_ff <= 1'b0;
    end else if (CLK_EN) begin
      sleep_cnt_ff <= nxt_sleep_cnt;
      asleep_ff <= (nxt_sleep_cnt == `SLEEP_DELAY);
    end
  end

  assign active = CLK_EN & ~CLK_GATE_N & ~asleep_ff;
  assign selected = ~CHIP_SEL_FIRST_N & CHIP_SEL_SECOND & ~CHIP_SEL_THIRD_N;
  assign any_byte = ~(&BYTE_WRITE_N);
  assign is_load = ~ADVANCE_LOAD;
  assign pipe_mode = FLOW_THROUGH_N;

  // burst counter forms the low bits
  burst_addr_gen u_burst (
    .clk(SYS_CLK),
    .srst(SRST),
    .ce(active),
    .load(is_load & selected),
    .advance(ADVANCE_LOAD),
    .interleave(LINEAR_ORDER_N),
    .start_low(ADDR[1:0]),
    .low_bits(low_bits)
  );

  assign cur_addr = {base_ff[ADDR_W-1:2], low_bits};
  // load uses external address, continue the counted one
  assign access_addr = is_load ? ADDR : cur_addr;

  // command decode for this edge
  always @* begin
    nxt_cmd = `CMD_DESEL;
    if (is_load) begin
      if (!selected) begin
        nxt_cmd = `CMD_DESEL;
      end else if (WRITE_N) begin
        nxt_cmd = `CMD_READ;
      end else if (any_byte) begin
        nxt_cmd = `CMD_WRITE;
      end else begin
        nxt_cmd = `CMD_DESEL;
      end
    end else begin
      if (last_cmd_ff == `CMD_DESEL) begin
        nxt_cmd = `CMD_DESEL;
      end else if (last_cmd_ff == `CMD_READ) begin
        nxt_cmd = `CMD_READ;
      end else if (any_byte) begin
        nxt_cmd = `CMD_WRITE;
      end else begin
        nxt_cmd = `CMD_ABORT;
      end
    end
  end
  assign wr_cycle = (nxt_cmd == `CMD_WRITE);
  assign rd_cycle = (nxt_cmd == `CMD_READ);

  assign land_vld = pipe_mode ? wr2_vld_ff : wr1_vld_ff;
  assign land_addr = pipe_mode ? wr2_addr_ff : wr1_addr_ff;
  assign land_be = pipe_mode ? wr2_be_ff : wr1_be_ff;

  // per-lane merge of incoming data into the stored word
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      assign merged[g*LANE_W +: LANE_W] = land_be[g] ? DQ_IN[g*LANE_W +: LANE_W]
                                                    : mem_ff[land_addr][g*LANE_W +: LANE_W];
    end
  endgenerate

  // control state, write pipeline and array write
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      base_ff <= {ADDR_W{1'b0}};
      last_cmd_ff <= `CMD_DESEL;
      wr1_vld_ff <= 1'b0;
      wr1_addr_ff <= {ADDR_W{1'b0}};
      wr1_be_ff <= {LANES{1'b0}};
      wr2_vld_ff <= 1'b0;
      wr2_addr_ff <= {ADDR_W{1'b0}};
      wr2_be_ff <= {LANES{1'b0}};
    end else if (active) begin
      last_cmd_ff <= nxt_cmd;
      if (is_load && selected) begin
        base_ff <= ADDR;
      end
      // stage one captures this edge's write, stage two delays it once more
      wr1_vld_ff <= wr_cycle;
      wr1_addr_ff <= access_addr;
      wr1_be_ff <= ~BYTE_WRITE_N;
      wr2_vld_ff <= wr1_vld_ff;
      wr2_addr_ff <= wr1_addr_ff;
      wr2_be_ff <= wr1_be_ff;
      if (land_vld) begin
        mem_ff[land_addr] <= merged;
      end
    end
  end

  // read word enters buffer when addressed; dropped when buffer is full
  assign rd_push = active & rd_cycle;
  // flow and pipe mode both drain one edge after the fill, while the state shows drive
  assign drain = active & (io_state_ff == ST_DRIVE);

  word_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(`FIFO_DEPTH_DEF),
    .PTR_W(2)
  ) u_fifo (
    .clk(SYS_CLK),
    .srst(SRST),
    .ce(CLK_EN),
    .in_valid(rd_push),
    .in_ready(fifo_in_ready),
    .in_data(mem_ff[access_addr]),
    .out_valid(fifo_out_valid),
    .out_ready(drain),
    .out_data(fifo_out_data)
  );

  // data i/o state: drive after read, float on write or deselect
  always @* begin
    nxt_io_state = io_state_ff;
    if (asleep_ff) begin
      nxt_io_state = ST_IDLE;
    end else if (rd_cycle) begin
      nxt_io_state = ST_DRIVE;
    end else if (wr_cycle || nxt_cmd == `CMD_ABORT) begin
      nxt_io_state = ST_WRITE;
    end else begin
      nxt_io_state = ST_IDLE;
    end
  end

  // output stage, every output from a flip-flop
  // float from reset
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      io_state_ff <= ST_IDLE;
      DQ_OUT <= {DATA_W{1'b0}};
      DQ_OE <= {DATA_W{1'b0}};
      ASLEEP <= 1'b0;
    end else if (CLK_EN) begin
      ASLEEP <= asleep_ff;
      if (asleep_ff) begin
        io_state_ff <= ST_IDLE;
        DQ_OE <= {DATA_W{1'b0}};
      // stall keeps read driven, write floated
      end else if (!active) begin
        // the output register is frozen too: hold the drive, only the enable pin may drop it
        DQ_OE <= oe_s2_ff ? {DATA_W{1'b0}} : DQ_OE;
      end else begin
        io_state_ff <= nxt_io_state;
        // flow drives now, pipe one edge later
        if (!pipe_mode && rd_cycle) begin
          DQ_OUT <= mem_ff[access_addr];
        end else if (pipe_mode && fifo_out_valid && io_state_ff == ST_DRIVE) begin
          DQ_OUT <= fifo_out_data;
        end
        if (pipe_mode) begin
          DQ_OE <= (io_state_ff == ST_DRIVE && !oe_s2_ff) ? {DATA_W{1'b1}} : {DATA_W{1'b0}};
        end else begin
          DQ_OE <= (rd_cycle && !oe_s2_ff) ? {DATA_W{1'b1}} : {DATA_W{1'b0}};
        end
      end
    end
  end
endmodule // sync_sram_burst_port

// ### verif/sync_sram_burst_port_chk.sv
// Purpose: port checks of the burst static RAM device side
// Assumes: one clock, sync reset, sees top ports only
// Notes: drive and sleep pins pass sync flops, so counters gate checks
`timescale 1ns/1ps
module sync_sram_burst_port_chk #(
  parameter LANES = 4,
  parameter LANE_W = 9
) (
  // clock and reset
  input wire SYS_CLK,
  input wire SRST,
  // command pins
  input wire CLK_EN,
  input wire CLK_GATE_N,
  input wire ADVANCE_LOAD,
  input wire WRITE_N,
  input wire CHIP_SEL_FIRST_N,
  input wire CHIP_SEL_SECOND,
  input wire CHIP_SEL_THIRD_N,
  // mode pins
  input wire OUT_DRIVE_N,
  input wire SLEEP_REQUEST,
  input wire FLOW_THROUGH_N,
  // outputs
  input wire [LANES*LANE_W-1:0] DQ_OUT,
  input wire [LANES*LANE_W-1:0] DQ_OE,
  input wire ASLEEP
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  wire act = CLK_EN && !CLK_GATE_N && !ASLEEP; // edge that acts
  wire sel = !CHIP_SEL_FIRST_N && CHIP_SEL_SECOND && !CHIP_SEL_THIRD_N; // all selects on
  wire flow = !FLOW_THROUGH_N; // flow-through mode
  wire rd = act && !ADVANCE_LOAD && WRITE_N && sel; // read begin
  wire desel = act && !ADVANCE_LOAD && !sel; // deselect on load
  wire [LANES*LANE_W-1:0] ones = {LANES*LANE_W{1'b1}};
  reg [1:0] on_ff; // cycles with drive on and awake
  reg [1:0] off_ff; // cycles with drive off
  // count only enabled edges, since the sync flops freeze with the clock enable
  always @(posedge SYS_CLK) begin
    if (SRST || OUT_DRIVE_N || SLEEP_REQUEST || ASLEEP) on_ff <= 2'h0;
    else if (CLK_EN && on_ff != 2'h3) on_ff <= on_ff + 2'h1;
    if (SRST || !OUT_DRIVE_N) off_ff <= 2'h0;
    else if (CLK_EN && off_ff != 2'h3) off_ff <= off_ff + 2'h1;
  end
  wire quiet = on_ff == 2'h3; // drive enable settled on
  wire dark = off_ff == 2'h3; // drive enable settled off
  AST_FLOW_READ: assert property (flow && quiet && rd |=> DQ_OE == ones)
    else $error("flow read not driven one cycle on");
  AST_PIPE_READ: assert property (!flow && quiet && rd ##1 (CLK_EN && !CLK_GATE_N) |=> DQ_OE == ones)
    else $error("pipelined read not driven two cycles on");
  AST_DUMMY_READ: assert property (flow && dark && act |=> DQ_OE == ~ones)
    else $error("bus driven with drive enable off");
  AST_WRITE_FLOAT: assert property (flow && act && !ADVANCE_LOAD && !WRITE_N |=> DQ_OE == ~ones)
    else $error("bus driven after write command");
  AST_DESELECT: assert property (flow && desel |=> DQ_OE == ~ones)
    else $error("bus driven after deselect");
  AST_DESEL_CONT: assert property (flow && desel ##1 (act && ADVANCE_LOAD) |=> DQ_OE == ~ones)
    else $error("bus driven in deselect continue");
  AST_STALL_HOLD: assert property (quiet && !(CLK_EN && !CLK_GATE_N) |=> $stable(DQ_OE) && $stable(DQ_OUT))
    else $error("outputs moved on an ignored edge");
  AST_SLEEP_FLOAT: assert property (ASLEEP && $past(ASLEEP) |-> DQ_OE == ~ones)
    else $error("bus driven while asleep");
  AST_SLEEP_ENTER: assert property ((SLEEP_REQUEST && CLK_EN) [*6] |-> ASLEEP)
    else $error("sleep not entered in time");
  AST_SLEEP_EARLY: assert property ($rose(SLEEP_REQUEST) && !ASLEEP |=> !ASLEEP)
    else $error("sleep entered at once");
  AST_RESET_FLOAT: assert property ($fell(SRST) |-> DQ_OE == ~ones && !ASLEEP)
    else $error("outputs not idle after reset");
endmodule // sync_sram_burst_port_chk
bind sync_sram_burst_port sync_sram_burst_port_chk #(.LANES(LANES), .LANE_W(LANE_W)) chk_i (
  .SYS_CLK(SYS_CLK), .SRST(SRST), .CLK_EN(CLK_EN), .CLK_GATE_N(CLK_GATE_N),
  .ADVANCE_LOAD(ADVANCE_LOAD), .WRITE_N(WRITE_N), .CHIP_SEL_FIRST_N(CHIP_SEL_FIRST_N),
  .CHIP_SEL_SECOND(CHIP_SEL_SECOND), .CHIP_SEL_THIRD_N(CHIP_SEL_THIRD_N),
  .OUT_DRIVE_N(OUT_DRIVE_N), .SLEEP_REQUEST(SLEEP_REQUEST), .FLOW_THROUGH_N(FLOW_THROUGH_N),
  .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .ASLEEP(ASLEEP));

// ### verif/sram_host_model.sv
// Purpose: controller model driving the burst static RAM pins
// Assumes: pins change 1 ns after the rising edge
// Notes: idle data lines flip each cycle so stale data never matches
`timescale 1ns/1ps
module sram_host_model (
  // clock and mode
  input wire SYS_CLK,
  input wire FLOW_THROUGH_N,
  // command pins
  output reg CLK_EN,
  output reg CLK_GATE_N,
  output reg [7:0] ADDR,
  output reg ADVANCE_LOAD,
  output reg WRITE_N,
  output reg [3:0] BYTE_WRITE_N,
  output reg CHIP_SEL_FIRST_N,
  output reg CHIP_SEL_SECOND,
  output reg CHIP_SEL_THIRD_N,
  // write data
  output reg [35:0] DQ_IN
);
  reg wflag = 1'b0; // command carries data
  reg [35:0] wdat = 36'h0; // its data
  reg v1_ff = 1'b0; // slot one edge on
  reg v2_ff = 1'b0; // slot two edges on
  reg [35:0] d1_ff;
  reg [35:0] d2_ff;
  initial begin
    {CLK_EN, CLK_GATE_N, ADDR, ADVANCE_LOAD, WRITE_N, BYTE_WRITE_N} = 16'h801f;
    {CHIP_SEL_FIRST_N, CHIP_SEL_SECOND, CHIP_SEL_THIRD_N} = 3'h6;
    DQ_IN = 36'h0;
  end
  // data slots shift on acting edges
  always @(posedge SYS_CLK) begin
    if (CLK_EN && !CLK_GATE_N) begin
      v1_ff <= wflag;
      d1_ff <= wdat;
      v2_ff <= v1_ff;
      d2_ff <= d1_ff;
    end
  end
  // data one or two edges late
  always @(posedge SYS_CLK) begin
    #1;
    if (FLOW_THROUGH_N ? v2_ff : v1_ff) DQ_IN = FLOW_THROUGH_N ? d2_ff : d1_ff;
    else DQ_IN = ~DQ_IN;
  end
  task cmd(input advance_load, input wr_n, input [3:0] be_n, input [2:0] sel, input [7:0] a,
    input [35:0] d);
    begin
      {ADVANCE_LOAD, WRITE_N, BYTE_WRITE_N, ADDR} = {advance_load, wr_n, be_n, a};
      {CHIP_SEL_FIRST_N, CHIP_SEL_SECOND, CHIP_SEL_THIRD_N} = sel;
      wdat = d;
      wflag = !wr_n && be_n != 4'hf && (advance_load || sel == 3'h2);
      @(posedge SYS_CLK);
      #1;
    end
  endtask
  // wait state by gate or enable
  task stall(input use_en);
    begin
      if (use_en) CLK_EN = 1'b0;
      else CLK_GATE_N = 1'b1;
      @(posedge SYS_CLK);
      #1;
      CLK_EN = 1'b1;
      CLK_GATE_N = 1'b0;
    end
  endtask
endmodule // sram_host_model

// ### verif/test_sync_sram_burst_port.sv
// Purpose: self-checking bench of the burst static RAM device side
// Assumes: host model drives commands, bench holds the memory image
// Notes: runs flow-through then pipelined, with random stalls
`timescale 1ns/1ps
module test_sync_sram_burst_port;
  localparam W = 36;
  reg SYS_CLK = 1'b0;
  reg SRST = 1'b1;
  reg OUT_DRIVE_N = 1'b0;
  reg SLEEP_REQUEST = 1'b0;
  reg LINEAR_ORDER_N = 1'b0;
  reg FLOW_THROUGH_N = 1'b0;
  wire CLK_EN, CLK_GATE_N, ADVANCE_LOAD, WRITE_N, ASLEEP;
  wire CHIP_SEL_FIRST_N, CHIP_SEL_SECOND, CHIP_SEL_THIRD_N;
  wire [7:0] ADDR;
  wire [3:0] BYTE_WRITE_N;
  wire [W-1:0] DQ_IN, DQ_OUT, DQ_OE;
  reg [W-1:0] mem [0:255]; // expected array image
  reg [W-1:0] exp_q [$]; // read results awaited
  integer seed = 52;
  integer n_mismatch = 0;
  integer n_checks = 0;
  integer m, k;
  reg prev_act = 1'b0; // last edge acted, so outputs are fresh
  always #10 SYS_CLK = ~SYS_CLK;
  sync_sram_burst_port sync_sram_burst_port_i (.SYS_CLK(SYS_CLK), .SRST(SRST),
    .CLK_EN(CLK_EN), .ADDR(ADDR), .CLK_GATE_N(CLK_GATE_N), .ADVANCE_LOAD(ADVANCE_LOAD),
    .WRITE_N(WRITE_N), .BYTE_WRITE_N(BYTE_WRITE_N), .CHIP_SEL_FIRST_N(CHIP_SEL_FIRST_N),
    .CHIP_SEL_SECOND(CHIP_SEL_SECOND), .CHIP_SEL_THIRD_N(CHIP_SEL_THIRD_N),
    .OUT_DRIVE_N(OUT_DRIVE_N), .SLEEP_REQUEST(SLEEP_REQUEST), .LINEAR_ORDER_N(LINEAR_ORDER_N),
    .FLOW_THROUGH_N(FLOW_THROUGH_N), .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE),
    .ASLEEP(ASLEEP));
  sram_host_model sram_host_model_i (.SYS_CLK(SYS_CLK), .FLOW_THROUGH_N(FLOW_THROUGH_N),
    .CLK_EN(CLK_EN), .CLK_GATE_N(CLK_GATE_N), .ADDR(ADDR), .ADVANCE_LOAD(ADVANCE_LOAD),
    .WRITE_N(WRITE_N), .BYTE_WRITE_N(BYTE_WRITE_N), .CHIP_SEL_FIRST_N(CHIP_SEL_FIRST_N),
    .CHIP_SEL_SECOND(CHIP_SEL_SECOND), .CHIP_SEL_THIRD_N(CHIP_SEL_THIRD_N), .DQ_IN(DQ_IN));
  task check_word(input string nm, input [W-1:0] exp, input [W-1:0] got);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task check_flag(input string nm, input exp, input got);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value %s expected %b seen %b", nm, exp, got);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  // a fresh driven word is a read result: take the oldest note
  always @(posedge SYS_CLK) begin
    if (prev_act && !SRST && DQ_OE !== {W{1'b0}}) begin
      if (exp_q.size() == 0) check_word("DQ_OE", {W{1'b0}}, DQ_OE);
      else begin
        check_word("DQ_OE", {W{1'b1}}, DQ_OE);
        check_word("DQ_OUT", exp_q.pop_front(), DQ_OUT);
      end
    end
    prev_act <= CLK_EN && !CLK_GATE_N;
  end
  task idle(input integer n);
    repeat (n) sram_host_model_i.cmd(1'b0, 1'b1, 4'hf, 3'h6, 8'h0, 36'h0);
  endtask
  // accesses k0 to k0+n-1 of a burst from a; stalls at random
  task burst(input wr, input [3:0] be, input [7:0] a, input integer k0, input integer n);
    integer i, j;
    reg [1:0] c;
    reg [7:0] ad;
    reg [W-1:0] d;
    begin
      for (i = k0; i < k0 + n; i = i + 1) begin
        c = i[1:0];
        ad = {a[7:2], LINEAR_ORDER_N ? a[1:0] ^ c : a[1:0] + c};
        d = W'({$random(seed), $random(seed)});
        for (j = 0; j < 4; j = j + 1) if (wr && !be[j]) mem[ad][j*9 +: 9] = d[j*9 +: 9];
        if (!wr && !OUT_DRIVE_N) exp_q.push_back(mem[ad]);
        sram_host_model_i.cmd(i != 0, !wr, be, 3'h2, a, d);
        if (($random(seed) & 3) == 0) sram_host_model_i.stall(($random(seed) & 1) != 0);
      end
    end
  endtask
  initial begin
    #2000000;
    n_mismatch = n_mismatch + 1;
    print_verdict;
  end
  initial begin
    for (m = 0; m < 2; m = m + 1) begin
      FLOW_THROUGH_N = m[0];
      SRST = 1'b1;
      repeat (20) @(posedge SYS_CLK);
      #1 SRST = 1'b0;
      idle(2);
      burst(1'b1, 4'h0, 8'h11, 0, 4);
      burst(1'b0, 4'h0, 8'h11, 0, 5);
      burst(1'b1, 4'h0, 8'h30, 0, 4);
      burst(1'b1, 4'h0, 8'h34, 0, 4);
      for (k = 0; k < 4; k = k + 1) burst(1'b1, ~(4'h1 << k), 8'h30 + k, 0, 1);
      burst(1'b1, 4'h0, 8'h34, 0, 1);
      burst(1'b1, 4'hf, 8'h34, 1, 1);
      burst(1'b1, 4'h0, 8'h34, 2, 1);
      for (k = 0; k < 3; k = k + 1) sram_host_model_i.cmd(1'b0, 1'b0, 4'h0,
        9'h183 >> (k * 3), 8'h30, 36'h0);
      sram_host_model_i.cmd(1'b1, 1'b0, 4'h0, 3'h2, 8'h30, 36'h0);
      burst(1'b0, 4'h0, 8'h30, 0, 4);
      burst(1'b0, 4'h0, 8'h34, 0, 4);
      LINEAR_ORDER_N = 1'b1;
      burst(1'b0, 4'h0, 8'h32, 0, 4);
      LINEAR_ORDER_N = 1'b0;
      idle(3);
      OUT_DRIVE_N = 1'b1;
      idle(3);
      burst(1'b0, 4'h0, 8'h11, 0, 2);
      idle(2);
      OUT_DRIVE_N = 1'b0;
      idle(3);
      SLEEP_REQUEST = 1'b1;
      idle(6);
      check_flag("ASLEEP", 1'b1, ASLEEP);
      sram_host_model_i.cmd(1'b0, 1'b0, 4'h0, 3'h2, 8'h11, 36'h0);
      SLEEP_REQUEST = 1'b0;
      idle(8);
      check_flag("ASLEEP", 1'b0, ASLEEP);
      burst(1'b0, 4'h0, 8'h11, 0, 1);
      idle(4);
      for (k = 0; k < 8 && exp_q.size() != 0; k = k + 1) @(posedge SYS_CLK);
      #1;
      check_word("reads left", {W{1'b0}}, W'(exp_q.size()));
      exp_q.delete();
    end
    print_verdict;
  end
endmodule // test_sync_sram_burst_port
